// >>> src/rxts_consts.svh
// Purpose: offsets, field positions, reset values for the rx timestamp csr bank
// Assumes: apb with 32-bit data, byte address = register index times four
// Notes:   included by the decode, timestamp unit and csr bank design files of the bank
`ifndef RXTS_CONSTS_SVH
`define RXTS_CONSTS_SVH

// ------------------------------------------------------------
// register indices (byte address is index << 2)
// ------------------------------------------------------------
`define RXTS_IDX_W          12
`define RXTS_IDX_REVISION   12'hb00
`define RXTS_IDX_SCRATCH    12'hb01
`define RXTS_IDX_NAME0      12'hb02
`define RXTS_IDX_NAME1      12'hb03
`define RXTS_IDX_NAME2      12'hb04
`define RXTS_IDX_PERIOD     12'hb05
`define RXTS_IDX_PMA_DELAY  12'hb06

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define RXTS_PERIOD_W        20
`define RXTS_PERIOD_NS_MSB   19
`define RXTS_PERIOD_NS_LSB   16
`define RXTS_PERIOD_FRAC_MSB 15
`define RXTS_SCRATCH_RESET   32'h0000_0000
`define RXTS_PERIOD_40G_RST  20'h4_0000
`define RXTS_PERIOD_100G_RST 20'h3_0000
`define RXTS_PMA_DELAY_RST   32'h0000_0000
`define RXTS_TOD_W           48

`endif

// >>> src/rxts_pkg.sv
// Purpose: shared types of the rx timestamp csr bank
// Assumes: constants live in rxts_consts.svh
// Notes:   register select is one-hot free, plain binary enum
package rxts_pkg;

   typedef enum logic [2:0] {
      RXTS_SEL_REVISION  = 3'h0,
      RXTS_SEL_SCRATCH   = 3'h1,
      RXTS_SEL_NAME0     = 3'h2,
      RXTS_SEL_NAME1     = 3'h3,
      RXTS_SEL_NAME2     = 3'h4,
      RXTS_SEL_PERIOD    = 3'h5,
      RXTS_SEL_PMA_DELAY = 3'h6,
      RXTS_SEL_NONE      = 3'h7
   } rxts_sel_t;

endpackage

// >>> src/rxts_tune_if.sv
// Purpose: carries programmed period and pma delay to the timestamp unit
// Assumes: both ends on pclk
// Notes:   csr end drives, timestamp end reads
`timescale 1ns/1ps
`default_nettype none
interface rxts_tune_if;
   logic [19:0] period;      // rx mac clock period, 4.16 ns fixed point
   logic [31:0] pma_delay;   // rx pma delay, 16.16 ns fixed point
   modport csr (output period, output pma_delay);
   modport ts  (input period, input pma_delay);
endinterface
`default_nettype wire

// >>> src/rxts_apb_decode.sv
// Purpose: apb address decode and strobes for the rx timestamp csr bank
// Assumes: zero wait state slave; paddr is a byte address
// Notes:   pready is always high, so every access phase completes
`timescale 1ns/1ps
`default_nettype none
`include "rxts_consts.svh"
module rxts_apb_decode
   import rxts_pkg::*;
#(
   parameter int PADDR_W = 16
) (
   input  wire logic               psel,      // apb select
   input  wire logic               penable,   // apb access phase
   input  wire logic               pwrite,    // apb direction
   input  wire logic [PADDR_W-1:0] paddr,     // apb byte address
   output logic                    pready,    // apb ready
   output logic                    pslverr,   // error on unmapped address
   output logic                    wr_en,     // write takes effect this edge
   output logic                    rd_setup,  // read setup, load read data
   output rxts_sel_t               sel        // decoded register
);
   logic [`RXTS_IDX_W-1:0] idx;
   logic                   high_zero;

   assign idx       = paddr[`RXTS_IDX_W+1:2];
   assign high_zero = (paddr[PADDR_W-1:`RXTS_IDX_W+2] == '0);

   always_comb begin
      sel = RXTS_SEL_NONE;
      if (high_zero) begin
         case (idx)
            `RXTS_IDX_REVISION:  sel = RXTS_SEL_REVISION;
            `RXTS_IDX_SCRATCH:   sel = RXTS_SEL_SCRATCH;
            `RXTS_IDX_NAME0:     sel = RXTS_SEL_NAME0;
            `RXTS_IDX_NAME1:     sel = RXTS_SEL_NAME1;
            `RXTS_IDX_NAME2:     sel = RXTS_SEL_NAME2;
            `RXTS_IDX_PERIOD:    sel = RXTS_SEL_PERIOD;
            `RXTS_IDX_PMA_DELAY: sel = RXTS_SEL_PMA_DELAY;
            default:             sel = RXTS_SEL_NONE;
         endcase
      end
   end

   assign pready   = 1'b1;
   assign pslverr  = psel & penable & (sel == RXTS_SEL_NONE);
   assign wr_en    = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
endmodule // rxts_apb_decode
`default_nettype wire

// >>> src/rxts_ts_unit.sv
// Purpose: rx time of day counter and arrival timestamp correction
// Assumes: frame start pulse from logic on pclk
// Notes:   timestamp is pulled back by the pma delay to the serial pin
`timescale 1ns/1ps
`default_nettype none
`include "rxts_consts.svh"
module rxts_ts_unit (
   input  wire logic                   pclk,        // clock
   input  wire logic                   presetn,     // async reset, active low
   rxts_tune_if.ts                     tune,        // programmed tuning
   input  wire logic                   frame_start, // frame start pulse
   output logic [`RXTS_TOD_W-1:0]      tod,         // time of day, 32.16 ns
   output logic                        ts_valid,    // timestamp pulse
   output logic [`RXTS_TOD_W-1:0]      ts_value     // corrected timestamp
);
   logic [`RXTS_TOD_W-1:0] next_tod;

   // time advances by the live period, so a rewrite applies next cycle
   assign next_tod = tod + {{(`RXTS_TOD_W-`RXTS_PERIOD_W){1'b0}}, tune.period};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tod <= '0;
      end else begin
         tod <= next_tod;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ts_valid <= 1'b0;
         ts_value <= '0;
      end else begin
         ts_valid <= frame_start;
         if (frame_start) begin
            ts_value <= tod - {16'h0000, tune.pma_delay};
         end
      end
   end
endmodule // rxts_ts_unit
`default_nettype wire

// >>> src/rxts_csr_bank.sv
// Purpose: rx timestamp control and status bank on apb, plus timestamp unit
// Assumes: apb master holds request until pready; frame_start on pclk
// Notes:   zero wait states; read data loaded in the setup cycle
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rxts_consts.svh"
module rxts_csr_bank
   import rxts_pkg::*;
#(
   parameter int          PADDR_W        = 16,
   parameter bit          VARIANT_100G   = 1'b0,
   // arbitrary value, stands in for a real revision code
   parameter logic [31:0] REVISION_CODE  = 32'h0000_0001,
   // arbitrary names, stand in for the variant strings
   parameter logic [95:0] NAME_40G       = "RXTSVARIANTA",
   parameter logic [95:0] NAME_100G      = "RXTSVARIANTB",
   parameter logic [19:0] PERIOD_40G     = `RXTS_PERIOD_40G_RST,
   parameter logic [19:0] PERIOD_100G    = `RXTS_PERIOD_100G_RST,
   parameter logic [31:0] PMA_DELAY_RST  = `RXTS_PMA_DELAY_RST
) (
   input  wire logic                    pclk,        // apb clock, 250 MHz
   input  wire logic                    presetn,     // async reset, active low
   input  wire logic                    psel,        // apb select
   input  wire logic                    penable,     // apb enable
   input  wire logic                    pwrite,      // apb direction
   input  wire logic [PADDR_W-1:0]      paddr,       // apb byte address
   input  wire logic [31:0]             pwdata,      // apb write data
   input  wire logic [3:0]              pstrb,       // apb byte strobes
   output logic [31:0]                  prdata,      // apb read data
   output logic                         pready,      // apb ready
   output logic                         pslverr,     // apb error
   input  wire logic                    frame_start, // rx frame start pulse
   output logic                         ts_valid,    // timestamp pulse
   output logic [`RXTS_TOD_W-1:0]       ts_value,    // corrected timestamp
   output logic [`RXTS_TOD_W-1:0]       tod          // running time of day
);

   // ------------------------------------------------------------
   // constants of this variant
   // ------------------------------------------------------------
   localparam logic [95:0] NAME       = VARIANT_100G ? NAME_100G : NAME_40G;
   localparam logic [19:0] PERIOD_RST = VARIANT_100G ? PERIOD_100G : PERIOD_40G;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   logic      wr_en;
   logic      rd_setup;
   rxts_sel_t sel;

   rxts_apb_decode #(
      .PADDR_W (PADDR_W)
   ) u_decode (
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pready   (pready),
      .pslverr  (pslverr),
      .wr_en    (wr_en),
      .rd_setup (rd_setup),
      .sel      (sel)
   );

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [31:0] scratch;
   logic [19:0] period;
   logic [31:0] pma_delay;
   logic [31:0] next_scratch;
   logic [31:0] next_period;
   logic [31:0] next_pma_delay;

   // byte lanes without a strobe keep their old contents
   function automatic logic [31:0] rxts_merge(
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = old_val;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_val[8*b +: 8];
         end
      end
      return res;
   endfunction

   assign next_scratch   = rxts_merge(scratch, pwdata, pstrb);
   assign next_period    = rxts_merge({12'h000, period}, pwdata, pstrb);
   assign next_pma_delay = rxts_merge(pma_delay, pwdata, pstrb);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scratch <= `RXTS_SCRATCH_RESET;
      end else if (wr_en && sel == RXTS_SEL_SCRATCH) begin
         scratch <= next_scratch;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         period <= PERIOD_RST;
      end else if (wr_en && sel == RXTS_SEL_PERIOD) begin
         period <= next_period[19:0];
      end
   end

   // default is trusted; software rarely needs to touch it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pma_delay <= PMA_DELAY_RST;
      end else if (wr_en && sel == RXTS_SEL_PMA_DELAY) begin
         pma_delay <= next_pma_delay;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [31:0] rd_word;

   // revision and name words have no write path at all
   always_comb begin
      case (sel)
         RXTS_SEL_REVISION:  rd_word = REVISION_CODE;
         RXTS_SEL_SCRATCH:   rd_word = scratch;
         RXTS_SEL_NAME0:     rd_word = NAME[95:64];
         RXTS_SEL_NAME1:     rd_word = NAME[63:32];
         RXTS_SEL_NAME2:     rd_word = NAME[31:0];
         RXTS_SEL_PERIOD:    rd_word = {12'h000, period};
         RXTS_SEL_PMA_DELAY: rd_word = pma_delay;
         default:            rd_word = 32'h0000_0000;
      endcase
   end

   // loaded in setup so read data comes from a flop in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_word;
      end
   end

   // ------------------------------------------------------------
   // timestamp unit
   // ------------------------------------------------------------
   rxts_tune_if tune ();

   assign tune.period    = period;
   assign tune.pma_delay = pma_delay;

   rxts_ts_unit u_ts (
      .pclk        (pclk),
      .presetn     (presetn),
      .tune        (tune.ts),
      .frame_start (frame_start),
      .tod         (tod),
      .ts_valid    (ts_valid),
      .ts_value    (ts_value)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_revision_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && sel == RXTS_SEL_REVISION |=> prdata == REVISION_CODE)
      else $error("revision word read wrong");

   a_scratch_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_en && sel == RXTS_SEL_SCRATCH && pstrb == 4'hf |=> scratch == $past(pwdata))
      else $error("scratch write not taken");

   a_scratch_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(wr_en && sel == RXTS_SEL_SCRATCH) |=> $stable(scratch))
      else $error("scratch changed without write");

   a_scratch_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && sel == RXTS_SEL_SCRATCH |=> prdata == $past(scratch))
      else $error("scratch readback wrong");

   a_name_first_word: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && sel == RXTS_SEL_NAME0 |=> prdata == NAME[95:64])
      else $error("name word 0 wrong");

   a_name_last_word: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && sel == RXTS_SEL_NAME2 |=> prdata == NAME[31:0])
      else $error("name word 2 wrong");

   a_period_upper_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && sel == RXTS_SEL_PERIOD |=> prdata[31:20] == 12'h000
                                              && prdata[19:0] == $past(period))
      else $error("period read layout wrong");

   a_period_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> period == PERIOD_RST)
      else $error("period reset value wrong");

   a_period_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_en && sel == RXTS_SEL_PERIOD && pstrb == 4'hf
      |=> period == $past(pwdata[19:0]))
      else $error("period write not taken");

   a_pma_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_en && sel == RXTS_SEL_PMA_DELAY && pstrb == 4'hf
      |=> pma_delay == $past(pwdata) ##1 $stable(pma_delay) || $past(wr_en))
      else $error("pma delay write not taken");

   a_tod_advance: assert property (
      @(posedge pclk) disable iff (!presetn)
      // gated by sampled reset: the release edge itself still holds tod at zero
      presetn |=> tod == $past(tod) + {28'h000_0000, $past(period)})
      else $error("time of day not advanced by period");

   a_ts_corrected: assert property (
      @(posedge pclk) disable iff (!presetn)
      frame_start |=> ts_valid && ts_value == $past(tod) - {16'h0000, $past(pma_delay)})
      else $error("timestamp not corrected by pma delay");

   a_unmapped_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable && sel == RXTS_SEL_NONE |-> pslverr && pready)
      else $error("unmapped access without error");

   // ------------------------------------------------------------
   // more register checks
   // ------------------------------------------------------------

   a_name_mid_word: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && sel == RXTS_SEL_NAME1 |=> prdata == NAME[63:32])
      else $error("name word 1 wrong");

   a_readonly_no_error: assert property (
      @(posedge pclk) disable iff (!presetn)
      wr_en && (sel == RXTS_SEL_REVISION || sel == RXTS_SEL_NAME0
                || sel == RXTS_SEL_NAME1 || sel == RXTS_SEL_NAME2) |-> !pslverr)
      else $error("write to read-only word raised error");

   a_scratch_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> scratch == `RXTS_SCRATCH_RESET)
      else $error("scratch reset value wrong");

   a_period_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(wr_en && sel == RXTS_SEL_PERIOD) |=> $stable(period))
      else $error("period changed without write");

   a_pma_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !(wr_en && sel == RXTS_SEL_PMA_DELAY) |=> $stable(pma_delay))
      else $error("pma delay changed without write");

   a_pma_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> pma_delay == PMA_DELAY_RST)
      else $error("pma delay reset value wrong");

   a_pma_readback: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && sel == RXTS_SEL_PMA_DELAY |=> prdata == $past(pma_delay))
      else $error("pma delay readback wrong");

   // ------------------------------------------------------------
   // bus and timestamp checks
   // ------------------------------------------------------------

   a_pready_access: assert property (
      @(posedge pclk) disable iff (!presetn)
      psel && penable |-> pready)
      else $error("access phase without ready");

   a_error_access_only: assert property (
      @(posedge pclk) disable iff (!presetn)
      pslverr |-> psel && penable && sel == RXTS_SEL_NONE)
      else $error("error outside unmapped access");

   a_read_unmapped_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && sel == RXTS_SEL_NONE |=> prdata == 32'h0000_0000)
      else $error("unmapped read data not zero");

   a_tod_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> tod == '0)
      else $error("time of day not cleared by reset");

   a_ts_single_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      !frame_start |=> !ts_valid)
      else $error("timestamp pulse without frame");

   a_ts_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      !frame_start |=> $stable(ts_value))
      else $error("timestamp changed without frame");

endmodule // rxts_csr_bank
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: self-checking bench for the rx timestamp csr bank over apb
// Assumes: zero to 15 wait states, byte address = register index times four
// Notes:   tod and timestamp checked against programmed period and pma delay
`timescale 1ns/1ps
`default_nettype none
`include "rxts_consts.svh"
module testbench;
   // arbitrary value, not a real revision code
   localparam logic [31:0] REV     = 32'h0000_00a5;
   localparam logic [95:0] NAME    = "TBVARIANTXYZ";
   localparam logic [95:0] NAME_B  = "TBVARIANTQRS";
   localparam logic [19:0] PER_DEF = `RXTS_PERIOD_40G_RST;
   localparam logic [31:0] PMA_DEF = 32'h0000_2400;
   localparam logic [15:0] A_REV   = 16'({`RXTS_IDX_REVISION, 2'h0});
   localparam logic [15:0] A_SCR   = 16'({`RXTS_IDX_SCRATCH, 2'h0});
   localparam logic [15:0] A_N0    = 16'({`RXTS_IDX_NAME0, 2'h0});
   localparam logic [15:0] A_N1    = 16'({`RXTS_IDX_NAME1, 2'h0});
   localparam logic [15:0] A_N2    = 16'({`RXTS_IDX_NAME2, 2'h0});
   localparam logic [15:0] A_PER   = 16'({`RXTS_IDX_PERIOD, 2'h0});
   localparam logic [15:0] A_PMA   = 16'({`RXTS_IDX_PMA_DELAY, 2'h0});
   localparam logic [15:0] A_BAD   = 16'h2c1c;

   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        frame_start, ts_valid;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, prdata_b;
   logic [3:0]  pstrb;
   logic [47:0] ts_value, tod;
   int          miscompares, samples_checked;

   rxts_csr_bank #(
      .VARIANT_100G  (1'b0),
      .REVISION_CODE (REV),
      .NAME_40G      (NAME),
      .PERIOD_40G    (PER_DEF),
      .PMA_DELAY_RST (PMA_DEF)
   ) u_rxts_csr_bank (
      .pclk        (pclk),
      .presetn     (presetn),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .pstrb       (pstrb),
      .prdata      (prdata),
      .pready      (pready),
      .pslverr     (pslverr),
      .frame_start (frame_start),
      .ts_valid    (ts_valid),
      .ts_value    (ts_value),
      .tod         (tod)
   );

   // other variant on the same bus, only its read data is watched
   rxts_csr_bank #(
      .VARIANT_100G  (1'b1),
      .REVISION_CODE (REV),
      .NAME_100G     (NAME_B),
      .PMA_DELAY_RST (PMA_DEF)
   ) u_rxts_csr_bank_b (
      .pclk        (pclk),
      .presetn     (presetn),
      .psel        (psel),
      .penable     (penable),
      .pwrite      (pwrite),
      .paddr       (paddr),
      .pwdata      (pwdata),
      .pstrb       (pstrb),
      .prdata      (prdata_b),
      .pready      (),
      .pslverr     (),
      .frame_start (frame_start),
      .ts_valid    (),
      .ts_value    (),
      .tod         ()
   );

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // ------------------------------------------------------------
   // apb master: setup, then access held until pready
   // ------------------------------------------------------------
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] wd,
                       input logic [3:0] st, output logic [31:0] rd, output logic err);
      int n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      pstrb   <= st;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         miscompares++;
         $display("MISMATCH t=%0t pready never came", $time);
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] st,
                     input logic exp_err);
      logic [31:0] rd;
      logic        err;
      xfer(1'b1, a, d, st, rd, err);
      chk(48'(err), 48'(exp_err));
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] d;
      logic        err;
      xfer(1'b0, a, 32'h0, 4'h0, d, err);
      chk(48'(d), 48'(exp));
      chk(48'(err), 48'(exp_err));
   endtask

   // tod must advance by exactly ten times the programmed period over ten cycles
   task automatic tod_step(input logic [19:0] p);
      logic [47:0] t0;
      @(posedge pclk);
      #1 t0 = tod;
      repeat (10) @(posedge pclk);
      #1 chk(tod - t0, 48'(p) * 48'd10);
   endtask

   // one frame: stamp is tod at the capture edge, pulled back by pma delay
   task automatic stamp(input logic [19:0] p, input logic [31:0] physical_medium_attachment);
      logic [47:0] t0;
      logic [47:0] s;
      @(posedge pclk);
      frame_start <= 1'b1;
      #1 t0 = tod;
      @(posedge pclk);
      frame_start <= 1'b0;
      #1 chk(48'(ts_valid), 48'h1);
      chk(tod - t0, 48'(p));
      s = ts_value + {16'h0, physical_medium_attachment};
      samples_checked++;
      if (s !== t0) begin
         miscompares++;
         $display("MISMATCH t=%0t stamp %h tod %h", $time, ts_value, t0);
      end
      @(posedge pclk);
      #1 chk(48'(ts_valid), 48'h0);
   endtask

   task automatic defaults();
      rd(A_SCR, `RXTS_SCRATCH_RESET, 1'b0);
      rd(A_PER, {12'h0, PER_DEF}, 1'b0);
      chk(48'(prdata_b), 48'(`RXTS_PERIOD_100G_RST));
      rd(A_PMA, PMA_DEF, 1'b0);
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0;
      pwdata = 32'h0;
      pstrb = 4'h0;
      frame_start = 1'b0;
      miscompares = 0;
      samples_checked = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_REV, REV, 1'b0);
      rd(A_N0, NAME[95:64], 1'b0);
      chk(48'(prdata_b), 48'(NAME_B[95:64]));
      rd(A_N1, NAME[63:32], 1'b0);
      rd(A_N2, NAME[31:0], 1'b0);
      chk(48'(prdata_b), 48'(NAME_B[31:0]));
      defaults();
      // read-only words ignore writes without error
      wr(A_REV, 32'hffff_ffff, 4'hf, 1'b0);
      wr(A_N1, 32'h0, 4'hf, 1'b0);
      rd(A_REV, REV, 1'b0);
      rd(A_N1, NAME[63:32], 1'b0);
      wr(A_SCR, 32'h1234_5678, 4'hf, 1'b0);
      wr(A_SCR, 32'haaaa_bbbb, 4'h5, 1'b0);
      rd(A_SCR, 32'h12aa_56bb, 1'b0);
      wr(A_BAD, 32'hdead_beef, 4'hf, 1'b1);
      rd(A_BAD, 32'h0, 1'b1);
      tod_step(PER_DEF);
      stamp(PER_DEF, PMA_DEF);
      wr(A_PER, 32'hfff1_8000, 4'hf, 1'b0);
      rd(A_PER, 32'h0001_8000, 1'b0);
      tod_step(20'h1_8000);
      wr(A_PMA, 32'h0003_4000, 4'hf, 1'b0);
      rd(A_PMA, 32'h0003_4000, 1'b0);
      stamp(20'h1_8000, 32'h0003_4000);
      // second reset in mid-run restores defaults
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      defaults();
      tod_step(PER_DEF);
      end_sim();
   end
endmodule // testbench
`default_nettype wire
